/* File: pcc_pkg.sv */
// Package of constants and types for the clock-conditioning control block
package pcc_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int CLK_FREQ_MHZ = 50;
  // Longest acquisition time from a cold start, microseconds
  localparam int ACQ_TIME_US = 80;
  // Whole cycles within the acquisition limit, rounded down
  localparam int ACQ_CYCLES = ACQ_TIME_US * CLK_FREQ_MHZ;
  localparam int ACQ_CNT_W = 13;

  // ****************************************************
  // Delay-line codes and their delay in picoseconds
  // ****************************************************
  localparam logic [1:0] DLY_CODE_NONE = 2'h0;
  localparam logic [1:0] DLY_CODE_SHORT = 2'h1;
  localparam logic [1:0] DLY_CODE_MID = 2'h2;
  localparam logic [1:0] DLY_CODE_LONG = 2'h3;
  localparam logic [12:0] DLY_NONE_PS = 13'h0000;
  localparam logic [12:0] DLY_SHORT_PS = 13'h00FA;
  localparam logic [12:0] DLY_MID_PS = 13'h01F4;
  localparam logic [12:0] DLY_LONG_PS = 13'h0FA0;

  // ****************************************************
  // Configuration word layout (divider fields hold value minus one)
  // ****************************************************
  localparam int CFG_W = 24;
  localparam int CFG_IN_DIV_LSB = 0;
  localparam int CFG_FB_DIV_LSB = 5;
  localparam int CFG_OUT_DIV_LSB = 12;
  localparam int CFG_PRI_DLY_LSB = 17;
  localparam int CFG_SEC_DLY_LSB = 19;
  localparam int CFG_BYPASS_BIT = 21;
  localparam int CFG_DLY_IN_FB_BIT = 22;
  localparam int CFG_FB_NETWORK_BIT = 23;
  localparam logic [CFG_W-1:0] NV_CONFIG_DEFAULT = 24'h000000;

  // ****************************************************
  // Register offsets and fields
  // ****************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SHADOW = 8'h08;
  localparam logic [7:0] REG_ACTIVE = 8'h0C;
  localparam logic [7:0] REG_INT_STATUS = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;
  localparam int CTRL_DYN_EN_BIT = 0;
  localparam int CTRL_SRC_JTAG_BIT = 1;
  localparam int CTRL_APPLY_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int INT_LOCK_GAINED = 0;
  localparam int INT_LOCK_LOST = 1;
  localparam int INT_CFG_APPLIED = 2;
  localparam int INT_W = 3;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Lock monitor states
  typedef enum {PCC_ACQUIRE, PCC_LOCKED} pcc_lock_state_t;

endpackage

/* File: pcc_clock_control.sv */
// Digital control of a clock-conditioning PLL with an AXI4-Lite register file
//
// Contract
// - Two-bit delay selects: 0, 0.25, 0.5, 4 ns
// - Active-high lock output only when locked; pll_lock also sets once the acquisition limit expires without core phase lock
// - Hold lock while reference jitter is tolerable
// - Settings from fixed bits or dynamic bits
// - Dynamic bits shift serially, present in parallel
// - Shift register loaded by user or test port
// - Fout equals fin times fb over in*out
// - Bypass routes reference through output delay
// - Feedback-path delay makes output clock lead
// - Network feedback aligns phase for zero skew
// - Lock within 80 us after cold start
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
module pcc_clock_control
  import pcc_pkg::*;
#(
  parameter int ACQ_LIMIT = ACQ_CYCLES,
  parameter logic [CFG_W-1:0] NV_CONFIG = NV_CONFIG_DEFAULT
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic user_cfg_sdi,
  input wire logic user_cfg_shift,
  input wire logic user_cfg_update,
  input wire logic jtag_cfg_sdi,
  input wire logic jtag_cfg_shift,
  input wire logic jtag_cfg_update,
  input wire logic ref_in_range,
  input wire logic ref_jitter_ok,
  input wire logic core_phase_locked,
  output logic pll_lock,
  output logic [4:0] input_div,
  output logic [6:0] feedback_div,
  output logic [4:0] output_div,
  output logic [1:0] primary_delay_select,
  output logic [1:0] secondary_delay_select,
  output logic [12:0] primary_delay_ps,
  output logic [12:0] secondary_delay_ps,
  output logic pll_bypass,
  output logic delay_in_feedback,
  output logic feedback_from_network,
  output logic [7:0] freq_mult,
  output logic [11:0] freq_div,
  output logic irq
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_fire;
  logic [1:0] ctrl, next_ctrl;
  logic apply_pulse, next_apply_pulse;
  logic [INT_W-1:0] int_status, next_int_status, int_mask, next_int_mask, int_event;
  logic [CFG_W-1:0] shadow, next_shadow, active, next_active, eff_cfg;
  logic dyn_loaded, next_dyn_loaded, cfg_update;
  pcc_lock_state_t lock_state, next_lock_state;
  logic [ACQ_CNT_W-1:0] acq_cnt, next_acq_cnt;
  logic lock_q, next_lock_q, ref_good;
  logic sel_sdi, sel_shift, sel_update;

  // Delay code to picoseconds
  // delay table
  function automatic logic [12:0] dly_ps(input logic [1:0] code);
    unique case (code)
      DLY_CODE_NONE: dly_ps = DLY_NONE_PS;
      DLY_CODE_SHORT: dly_ps = DLY_SHORT_PS;
      DLY_CODE_MID: dly_ps = DLY_MID_PS;
      DLY_CODE_LONG: dly_ps = DLY_LONG_PS;
    endcase
  endfunction

  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign wr_fire = aw_held && w_held;

  // Address and data captured in either order, answered once both held
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        REG_CTRL, REG_STATUS, REG_SHADOW, REG_ACTIVE, REG_INT_STATUS, REG_INT_MASK:
          next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    else if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
  end

  // Read decode, answered one cycle after the address is taken
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: next_rdata = {30'h00000000, ctrl};
        REG_STATUS: next_rdata = {29'h00000000, dyn_loaded,
                                  lock_state == PCC_ACQUIRE, lock_q};
        REG_SHADOW: next_rdata = {8'h00, shadow};
        REG_ACTIVE: next_rdata = {8'h00, eff_cfg};
        REG_INT_STATUS: next_rdata = {29'h00000000, int_status};
        REG_INT_MASK: next_rdata = {29'h00000000, int_mask};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  // Bus handshake registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ****************************************************
  // Control, interrupt status and mask
  // ****************************************************
  assign irq = |(int_status & int_mask);

  // Writes on byte lane 0; a new event wins over a clearing one
  always_comb
  begin
    next_ctrl = ctrl;
    next_int_mask = int_mask;
    next_apply_pulse = 1'b0;
    next_int_status = int_status;
    if (wr_fire && w_strb[0])
    begin
      if (aw_addr == REG_CTRL)
      begin
        next_ctrl = w_data[1:0];
        next_apply_pulse = w_data[CTRL_APPLY_BIT];
      end
      if (aw_addr == REG_INT_MASK)
        next_int_mask = w_data[INT_W-1:0];
      if (aw_addr == REG_INT_STATUS)
        next_int_status = int_status & ~w_data[INT_W-1:0];
    end
    next_int_status = next_int_status | int_event;
  end

  // Control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RESET;
      int_mask <= INT_RESET;
      int_status <= INT_RESET;
      apply_pulse <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      int_mask <= next_int_mask;
      int_status <= next_int_status;
      apply_pulse <= next_apply_pulse;
    end
  end

  // ****************************************************
  // Configuration shift register
  // ****************************************************
  // source select
  assign sel_sdi = ctrl[CTRL_SRC_JTAG_BIT] ? jtag_cfg_sdi : user_cfg_sdi;
  assign sel_shift = ctrl[CTRL_SRC_JTAG_BIT] ? jtag_cfg_shift : user_cfg_shift;
  assign sel_update = ctrl[CTRL_SRC_JTAG_BIT] ? jtag_cfg_update : user_cfg_update;
  assign cfg_update = sel_update || apply_pulse;
  assign eff_cfg = (ctrl[CTRL_DYN_EN_BIT] && dyn_loaded) ? active : NV_CONFIG;

  always_comb
  begin
    next_shadow = shadow;
    next_active = active;
    next_dyn_loaded = dyn_loaded;
    if (sel_shift)
      next_shadow = {shadow[CFG_W-2:0], sel_sdi};
    if (cfg_update)
    begin
      next_active = shadow;
      next_dyn_loaded = 1'b1;
    end
  end

  // Shadow and active words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shadow <= NV_CONFIG_DEFAULT;
      active <= NV_CONFIG_DEFAULT;
      dyn_loaded <= 1'b0;
    end
    else
    begin
      shadow <= next_shadow;
      active <= next_active;
      dyn_loaded <= next_dyn_loaded;
    end
  end

  // ****************************************************
  // Lock monitor
  // ****************************************************
  // reference must be usable
  assign ref_good = ref_in_range && ref_jitter_ok;
  assign pll_lock = lock_q;
  assign int_event = {cfg_update, lock_q && !next_lock_q, !lock_q && next_lock_q};

  // Acquire until the core reports phase lock or the limit expires
  always_comb
  begin
    next_lock_state = lock_state;
    next_acq_cnt = acq_cnt;
    unique case (lock_state)
      PCC_ACQUIRE:
      begin
        if (!ref_good)
          next_acq_cnt = '0;
        else if (core_phase_locked || acq_cnt == ACQ_CNT_W'(ACQ_LIMIT - 1))
          next_lock_state = PCC_LOCKED;
        else
          next_acq_cnt = acq_cnt + 1'b1;
      end
      PCC_LOCKED:
      begin
        if (!ref_good)
          next_lock_state = PCC_ACQUIRE;
      end
    endcase
    if (cfg_update)
    begin
      next_lock_state = PCC_ACQUIRE;
      next_acq_cnt = '0;
    end
    if (next_lock_state == PCC_ACQUIRE && lock_state == PCC_LOCKED)
      next_acq_cnt = '0;
    next_lock_q = (next_lock_state == PCC_LOCKED);
  end

  // Lock state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_state <= PCC_ACQUIRE;
      acq_cnt <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      lock_state <= next_lock_state;
      acq_cnt <= next_acq_cnt;
      lock_q <= next_lock_q;
    end
  end

  // ****************************************************
  // Outputs to the analog core
  // ****************************************************
  // Decoded settings registered once per cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      input_div <= 5'h00;
      feedback_div <= 7'h00;
      output_div <= 5'h00;
      primary_delay_select <= DLY_CODE_NONE;
      secondary_delay_select <= DLY_CODE_NONE;
      primary_delay_ps <= DLY_NONE_PS;
      secondary_delay_ps <= DLY_NONE_PS;
      pll_bypass <= 1'b0;
      delay_in_feedback <= 1'b0;
      feedback_from_network <= 1'b0;
      freq_mult <= 8'h01;
      freq_div <= 12'h001;
    end
    else
    begin
      input_div <= eff_cfg[CFG_IN_DIV_LSB +: 5];
      feedback_div <= eff_cfg[CFG_FB_DIV_LSB +: 7];
      output_div <= eff_cfg[CFG_OUT_DIV_LSB +: 5];
      primary_delay_select <= eff_cfg[CFG_PRI_DLY_LSB +: 2];
      secondary_delay_select <= eff_cfg[CFG_SEC_DLY_LSB +: 2];
      primary_delay_ps <= dly_ps(eff_cfg[CFG_PRI_DLY_LSB +: 2]);
      secondary_delay_ps <= dly_ps(eff_cfg[CFG_SEC_DLY_LSB +: 2]);
      pll_bypass <= eff_cfg[CFG_BYPASS_BIT];
      delay_in_feedback <= eff_cfg[CFG_DLY_IN_FB_BIT];
      feedback_from_network <= eff_cfg[CFG_FB_NETWORK_BIT];
      if (eff_cfg[CFG_BYPASS_BIT])
      begin
        freq_mult <= 8'h01;
        freq_div <= 12'h001;
      end
      else
      begin
        freq_mult <= {1'b0, eff_cfg[CFG_FB_DIV_LSB +: 7]} + 8'h01;
        freq_div <= ({7'h00, eff_cfg[CFG_IN_DIV_LSB +: 5]} + 12'h001)
                    * ({7'h00, eff_cfg[CFG_OUT_DIV_LSB +: 5]} + 12'h001);
      end
    end
  end

endmodule

/* File: pcc_clock_control_chk.sv */
// Concurrent checks on the clock-conditioning control ports
module pcc_clock_control_chk
  import pcc_pkg::*;
#(
  parameter int ACQ_LIMIT = ACQ_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ref_in_range,
  input wire logic ref_jitter_ok,
  input wire logic core_phase_locked,
  input wire logic pll_lock,
  input wire logic [6:0] feedback_div,
  input wire logic [1:0] primary_delay_select,
  input wire logic [1:0] secondary_delay_select,
  input wire logic [12:0] primary_delay_ps,
  input wire logic [12:0] secondary_delay_ps,
  input wire logic pll_bypass,
  input wire logic [7:0] freq_mult,
  input wire logic [11:0] freq_div
);
  // ****************
  // Helper logic
  // ****************
  logic good;
  logic [13:0] good_cnt;
  logic [13:0] next_good_cnt;
  // Reference usable per the detectors
  assign good = ref_in_range && ref_jitter_ok;
  // Good cycles spent without lock
  always_comb next_good_cnt = (pll_lock || !good) ? 14'h0000 : good_cnt + 14'h0001;
  // Counter register
  always_ff @(posedge aclk) good_cnt <= aresetn ? next_good_cnt : 14'h0000;
  // Delay of a select code in picoseconds
  function automatic logic [12:0] ps_of(input logic [1:0] c);
    return (c == 2'h0) ? 13'h0000 : (c == 2'h1) ? 13'h00FA : (c == 2'h2) ? 13'h01F4 : 13'h0FA0;
  endfunction
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************
  // Assertions
  // ****************
  a_lock_cause: assert property ($rose(pll_lock) |-> $past(good))
    else $error("lock rose without a usable reference");
  a_lock_fast: assert property (good && core_phase_locked && !pll_lock |=> pll_lock)
    else $error("lock missed a phase lock");
  a_lock_drop: assert property (!good |=> !pll_lock)
    else $error("lock held with a bad reference");
  a_acq_bound: assert property (good_cnt <= 14'(ACQ_LIMIT))
    else $error("acquisition took too long");
  a_pri_delay: assert property (primary_delay_ps == ps_of(primary_delay_select))
    else $error("primary delay value wrong");
  a_sec_delay: assert property (secondary_delay_ps == ps_of(secondary_delay_select))
    else $error("secondary delay value wrong");
  a_mult_field: assert property (!pll_bypass |-> freq_mult == {1'b0, feedback_div} + 8'h01)
    else $error("multiplier does not follow feedback divider");
  a_bypass_unity: assert property (pll_bypass |-> freq_mult == 8'h01 && freq_div == 12'h001)
    else $error("bypass ratio not unity");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  c_lock_gain: cover property ($rose(pll_lock));
  c_bypass: cover property (pll_bypass);
  c_read: cover property (s_axi_rvalid);
endmodule
bind pcc_clock_control pcc_clock_control_chk #(.ACQ_LIMIT(ACQ_LIMIT)) u_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
  .ref_in_range, .ref_jitter_ok, .core_phase_locked, .pll_lock, .feedback_div,
  .primary_delay_select, .secondary_delay_select, .primary_delay_ps,
  .secondary_delay_ps, .pll_bypass, .freq_mult, .freq_div);

/* File: pcc_far_model.sv */
// Far-side model that loads the configuration chain
module pcc_far_model
  import pcc_pkg::*;
(
  input wire logic aclk,
  input wire logic start,
  input wire logic use_jtag,
  input wire logic [CFG_W-1:0] word,
  output logic busy,
  output logic user_cfg_sdi,
  output logic user_cfg_shift,
  output logic user_cfg_update,
  output logic jtag_cfg_sdi,
  output logic jtag_cfg_shift,
  output logic jtag_cfg_update
);
  logic [4:0] step = 5'h00;
  logic [CFG_W-1:0] sr = '0;
  logic tog = 1'b0;
  logic sh;
  logic up;
  always_ff @(posedge aclk)
  begin
    tog <= !tog;
    step <= start ? 5'h01 : (step == 5'h19 || step == 5'h00) ? 5'h00 : step + 5'h01;
    sr <= start ? word : sh ? {sr[CFG_W-2:0], 1'b0} : sr;
  end
  // Shift for 24 steps, then one update
  assign sh = step != 5'h00 && step != 5'h19;
  assign up = step == 5'h19;
  assign busy = step != 5'h00;
  // Chosen path only, idle data toggles
  assign user_cfg_sdi = (sh && !use_jtag) ? sr[CFG_W-1] : tog;
  assign user_cfg_shift = sh && !use_jtag;
  assign user_cfg_update = up && !use_jtag;
  assign jtag_cfg_sdi = (sh && use_jtag) ? sr[CFG_W-1] : !tog;
  assign jtag_cfg_shift = sh && use_jtag;
  assign jtag_cfg_update = up && use_jtag;
endmodule

/* File: pcc_clock_control_bench.sv */
// Self-checking bench for the clock-conditioning control block
module pcc_clock_control_bench
  import pcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACQ = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, core_phase_locked = 1'b0;
  logic ref_in_range = 1'b1, ref_jitter_ok = 1'b1;
  logic start = 1'b0, use_jtag = 1'b0, busy;
  logic [23:0] word = 24'h0;
  logic user_cfg_sdi, user_cfg_shift, user_cfg_update;
  logic jtag_cfg_sdi, jtag_cfg_shift, jtag_cfg_update;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pll_lock, irq, pll_bypass, delay_in_feedback, feedback_from_network;
  logic [1:0] s_axi_bresp, s_axi_rresp, primary_delay_select, secondary_delay_select;
  logic [31:0] s_axi_rdata;
  logic [4:0] input_div, output_div;
  logic [6:0] feedback_div;
  logic [12:0] primary_delay_ps, secondary_delay_ps;
  logic [7:0] freq_mult;
  logic [11:0] freq_div;
  logic [2:0] modes;
  int mismatches = 0, n_checks = 0;
  // Clock and mode flags
  always #10 aclk = ~aclk;
  assign modes = {pll_bypass, delay_in_feedback, feedback_from_network};
  pcc_clock_control #(.ACQ_LIMIT(ACQ)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .user_cfg_sdi,
    .user_cfg_shift, .user_cfg_update, .jtag_cfg_sdi, .jtag_cfg_shift, .jtag_cfg_update,
    .ref_in_range, .ref_jitter_ok, .core_phase_locked, .pll_lock, .input_div,
    .feedback_div, .output_div, .primary_delay_select, .secondary_delay_select,
    .primary_delay_ps, .secondary_delay_ps, .pll_bypass, .delay_in_feedback,
    .feedback_from_network, .freq_mult, .freq_div, .irq);
  pcc_far_model far (.aclk, .start, .use_jtag, .word, .busy, .user_cfg_sdi,
    .user_cfg_shift, .user_cfg_update, .jtag_cfg_sdi, .jtag_cfg_shift, .jtag_cfg_update);
  // ****************
  // Tasks
  // ****************
  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stall();
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  // Bus write, response compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    if (s_axi_bvalid !== 1'b1) stall();
    s_axi_bready <= 1'b0;
    chk(34'(s_axi_bresp), 34'(e));
  endtask
  // Bus read, response and data compared
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    if (s_axi_rvalid !== 1'b1) stall();
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, e);
  endtask
  task automatic wait_lock(input logic v, input int lim);
    int n;
    n = 0;
    while (pll_lock !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    if (pll_lock !== v) stall();
  endtask
  // Serial load through the far-side model
  task automatic load(input logic [23:0] w, input logic j);
    int n;
    n = 0;
    start <= 1'b1;
    word <= w;
    use_jtag <= j;
    @(posedge aclk);
    start <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (busy !== 1'b0) stall();
  endtask
  // Delays of 0, 250, 500 and 4000 ps
  function automatic logic [12:0] dly(input logic [1:0] c);
    return (c == 2'h0) ? 13'h0000 : (c == 2'h1) ? 13'h00FA : (c == 2'h2) ? 13'h01F4 : 13'h0FA0;
  endfunction
  // ****************
  // Sequence
  // ****************
  initial
  begin
    logic [23:0] cfg;
    logic [1:0] c;
    logic b;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_CTRL, 34'h0);
    rd(REG_INT_MASK, 34'h0);
    rd(REG_SHADOW, 34'h0);
    rd(REG_STATUS, 34'h2);
    wait_lock(1'b1, ACQ + 2);
    rd(REG_INT_STATUS, 34'h1);
    wr(REG_INT_MASK, 32'h7, RESP_OKAY);
    chk(34'(irq), 34'h1);
    wr(REG_INT_STATUS, 32'h1, RESP_OKAY);
    chk(34'(irq), 34'h0);
    wr(8'h20, 32'h5, RESP_SLVERR);
    rd(8'h20, {RESP_SLVERR, 32'h0});
    wr(REG_SHADOW, 32'hFFFFFFFF, RESP_OKAY);
    rd(REG_SHADOW, 34'h0);
    ref_jitter_ok <= 1'b0;
    wait_lock(1'b0, 3);
    rd(REG_INT_STATUS, 34'h2);
    ref_jitter_ok <= 1'b1;
    core_phase_locked <= 1'b1;
    wait_lock(1'b1, 3);
    core_phase_locked <= 1'b0;
    wr(REG_INT_STATUS, 32'h7, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      b = c == 2'h3;
      cfg = {b ? 3'h7 : 3'h0, ~c, c, 5'h01, 7'h04, 5'h02};
      wr(REG_CTRL, {30'h0, c[0], 1'b1}, RESP_OKAY);
      load(cfg, c[0]);
      chk(34'(pll_lock), 34'h0);
      wait_lock(1'b1, ACQ + 2);
      chk(34'({primary_delay_select, secondary_delay_select}), 34'({c, ~c}));
      chk(34'({primary_delay_ps, secondary_delay_ps}), 34'({dly(c), dly(~c)}));
      chk(34'({input_div, feedback_div, output_div}), 34'({5'h02, 7'h04, 5'h01}));
      chk(34'({freq_mult, freq_div}), b ? 34'h01001 : 34'h05006);
      chk(34'(modes), 34'({3{b}}));
      rd(REG_ACTIVE, 34'(cfg));
      rd(REG_CTRL, 34'({c[0], 1'b1}));
    end
    load(24'hABCDEF, 1'b0);
    rd(REG_ACTIVE, 34'(cfg));
    chk(34'(pll_lock), 34'h1);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(34'({freq_mult, freq_div, pll_bypass}), 34'({8'h01, 12'h001, 1'b0}));
    rd(REG_ACTIVE, 34'h0);
    rd(REG_STATUS, 34'h5);
    wr(REG_INT_STATUS, 32'h7, RESP_OKAY);
    chk(34'(irq), 34'h0);
    // Apply bit copies the held shadow word without a serial update
    wr(REG_CTRL, 32'h5, RESP_OKAY);
    rd(REG_STATUS, 34'h6);
    rd(REG_INT_STATUS, 34'h6);
    chk(34'(irq), 34'h1);
    rd(REG_CTRL, 34'h1);
    rd(REG_ACTIVE, 34'(cfg));
    complete_run();
  end
endmodule
